// File: inc/sdmpr_pkg.sv
package sdmpr_pkg;
  // Avalon register word offsets (byte address = 4 x index)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_DATA   = 4'h2;
  localparam logic [3:0] REG_TIMING = 4'h3;
  // Control register fields
  localparam int CTRL_GO      = 0;
  localparam int CTRL_PAGE_LO = 1;
  localparam int CTRL_LOC_LO  = 3;
  localparam int CTRL_FMT_LO  = 5;
  localparam int CTRL_ORDER   = 7;
  localparam int CTRL_CHOP    = 8;
  localparam int CTRL_TEMP    = 9;
  localparam int CTRL_OTF     = 10;
  localparam int CTRL_PARLOG  = 11;
  // Mode register three fields and read command address bits
  localparam int MR3_PAGE_LO  = 0;
  localparam int MR3_ENABLE   = 2;
  localparam int MR3_TEMP     = 5;
  localparam int MR3_FMT_LO   = 11;
  localparam int ADDR_ORDER   = 2;
  localparam int ADDR_CHOP    = 12;
  localparam logic [1:0] MR3_SEL = 2'h3;
  localparam logic [1:0] FMT_SERIAL   = 2'h0;
  localparam logic [1:0] FMT_PARALLEL = 2'h1;
  localparam logic [1:0] PAGE_TRAIN   = 2'h0;
  localparam logic [1:0] PAGE_PARITY  = 2'h1;
  // Command codes on the simplified command port
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_PRE = 3'h1;
  localparam logic [2:0] CMD_MRW = 3'h2;
  localparam logic [2:0] CMD_RD  = 3'h3;
  // Default timing counts in sys_clk cycles
  localparam logic [7:0] DEF_PRE     = 8'h04;
  localparam logic [7:0] DEF_MRD_MOD = 8'h18;
  localparam logic [7:0] DEF_CCD_S   = 8'h04;
  localparam logic [7:0] DEF_CCD_L   = 8'h06;
  localparam logic [7:0] DEF_RECOV   = 8'h02;
  localparam logic [7:0] DEF_RL      = 8'h10;
  localparam logic [3:0] BEATS_FULL  = 4'h8;
  localparam logic [3:0] BEATS_CHOP  = 4'h4;
  localparam int TIMING_W = 8;
  typedef enum logic [3:0] {
    ST_IDLE, ST_PRE, ST_PRE_WAIT, ST_ENTER, ST_ENTER_WAIT, ST_READ,
    ST_CAPTURE, ST_RECOVER, ST_EXIT, ST_EXIT_WAIT
  } sdmpr_state_t;
endpackage

// File: hw/sdmpr_ctrl.sv
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module sdmpr_ctrl #(
  parameter int DQ_W = 8
) (
  // System
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Avalon-MM slave
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  // SDRAM command and address
  output logic      [2:0]         cmd,
  output logic      [17:0]        addr,
  output logic      [1:0]         bank_addr,
  output logic      [1:0]         bank_group,
  // SDRAM data and strobe inputs
  input  wire logic [DQ_W-1:0]    dq_in,
  input  wire logic               dqs_in
);
  sdmpr_pkg::sdmpr_state_t state;
  logic [11:0]          ctrl;
  logic [31:0]          timing;
  logic [7:0]           rl_cnt;
  logic [7:0]           wait_cnt;
  logic [7:0]           data_word;
  logic [3:0]           beat;
  logic                 busy;
  logic                 done;
  logic                 bad_req;
  logic                 ack;
  logic [DQ_W-1:0]      dq_s1;
  logic [DQ_W-1:0]      dq_s2;
  logic                 dqs_s1;
  logic                 dqs_s2;
  logic                 dqs_prev;
  logic [1:0]           page;
  logic [1:0]           loc;
  logic [1:0]           fmt;
  logic [3:0]           beats;
  logic [7:0]           frame_mask;

  // Address bit 17 is never logged, so its frame bit is forced to zero
  assign frame_mask = (page == sdmpr_pkg::PAGE_PARITY && loc == 2'h2) ? 8'hFD
                                                                      : 8'hFF;
  assign page  = ctrl[sdmpr_pkg::CTRL_PAGE_LO +: 2];
  assign loc   = ctrl[sdmpr_pkg::CTRL_LOC_LO +: 2];
  assign fmt   = ctrl[sdmpr_pkg::CTRL_FMT_LO +: 2];
  assign beats = ctrl[sdmpr_pkg::CTRL_CHOP] ? sdmpr_pkg::BEATS_CHOP
                                            : sdmpr_pkg::BEATS_FULL;

  // Parallel format on a nonzero location is refused before any command
  function automatic logic illegal(input logic [1:0] f, input logic [1:0] l,
                                   input logic [1:0] p, input logic pl);
    illegal = (f == sdmpr_pkg::FMT_PARALLEL && l != 2'h0)
           || (f == 2'h3)
           || (p == sdmpr_pkg::PAGE_PARITY && !pl);
  endfunction

  // Bus slave: one wait cycle for every access keeps timing simple
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl   <= '0;
      timing <= {sdmpr_pkg::DEF_RL, sdmpr_pkg::DEF_CCD_L,
                 sdmpr_pkg::DEF_CCD_S, sdmpr_pkg::DEF_MRD_MOD};
    end else begin
      if (avs_write && ack && !busy) begin
        if (avs_address == sdmpr_pkg::REG_CTRL) begin
          ctrl <= avs_writedata[11:0];
        end else if (avs_address == sdmpr_pkg::REG_TIMING) begin
          timing <= avs_writedata;
        end
      end
      if (state == sdmpr_pkg::ST_PRE) begin
        ctrl[sdmpr_pkg::CTRL_GO] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack) begin
      if (avs_address == sdmpr_pkg::REG_CTRL) begin
        avs_readdata <= {20'h00000, ctrl};
      end else if (avs_address == sdmpr_pkg::REG_STATUS) begin
        avs_readdata <= {29'h00000000, bad_req, done, busy};
      end else if (avs_address == sdmpr_pkg::REG_DATA) begin
        avs_readdata <= {24'h000000, data_word & frame_mask};
      end else if (avs_address == sdmpr_pkg::REG_TIMING) begin
        avs_readdata <= timing;
      end else begin
        avs_readdata <= '0;
      end
    end
  end

  // Pin inputs pass two flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dq_s1  <= '0;
      dq_s2  <= '0;
      dqs_s1 <= 1'b0;
      dqs_s2 <= 1'b0;
      dqs_prev <= 1'b0;
    end else begin
      dq_s1  <= dq_in;
      dq_s2  <= dq_s1;
      dqs_s1 <= dqs_in;
      dqs_s2 <= dqs_s1;
      dqs_prev <= dqs_s2;
    end
  end

  assign busy = (state != sdmpr_pkg::ST_IDLE);

  // Sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state     <= sdmpr_pkg::ST_IDLE;
      cmd       <= sdmpr_pkg::CMD_NOP;
      addr      <= '0;
      bank_addr <= '0;
      bank_group <= '0;
      wait_cnt  <= '0;
      rl_cnt    <= '0;
      beat      <= '0;
      data_word <= '0;
      done      <= 1'b0;
      bad_req   <= 1'b0;
    end else begin
      cmd <= sdmpr_pkg::CMD_NOP;
      if (wait_cnt != 8'h00) begin
        wait_cnt <= wait_cnt - 8'h01;
      end
      case (state)
        sdmpr_pkg::ST_IDLE: begin
          if (ctrl[sdmpr_pkg::CTRL_GO]) begin
            if (illegal(fmt, loc, page, ctrl[sdmpr_pkg::CTRL_PARLOG])) begin
              bad_req <= 1'b1;
            end else begin
              bad_req <= 1'b0;
              done    <= 1'b0;
              state   <= sdmpr_pkg::ST_PRE;
            end
          end
        end
        sdmpr_pkg::ST_PRE: begin
          cmd      <= sdmpr_pkg::CMD_PRE;
          addr     <= 18'h00400;
          wait_cnt <= sdmpr_pkg::DEF_PRE;
          state    <= sdmpr_pkg::ST_PRE_WAIT;
        end
        sdmpr_pkg::ST_PRE_WAIT: begin
          if (wait_cnt == 8'h00) begin
            state <= sdmpr_pkg::ST_ENTER;
          end
        end
        sdmpr_pkg::ST_ENTER: begin
          cmd        <= sdmpr_pkg::CMD_MRW;
          bank_addr  <= sdmpr_pkg::MR3_SEL;
          bank_group <= '0;
          addr       <= '0;
          addr[sdmpr_pkg::MR3_ENABLE]     <= 1'b1;
          addr[sdmpr_pkg::MR3_PAGE_LO +: 2] <= page;
          addr[sdmpr_pkg::MR3_FMT_LO +: 2]  <= fmt;
          addr[sdmpr_pkg::MR3_TEMP] <= ctrl[sdmpr_pkg::CTRL_TEMP];
          wait_cnt <= timing[7:0];
          state    <= sdmpr_pkg::ST_ENTER_WAIT;
        end
        sdmpr_pkg::ST_ENTER_WAIT: begin
          if (wait_cnt == 8'h00) begin
            state <= sdmpr_pkg::ST_READ;
          end
        end
        sdmpr_pkg::ST_READ: begin
          cmd       <= sdmpr_pkg::CMD_RD;
          bank_addr <= loc;
          addr      <= '0;
          addr[sdmpr_pkg::ADDR_ORDER] <= ctrl[sdmpr_pkg::CTRL_ORDER];
          // Chop bit must read one when on-the-fly is programmed
          addr[sdmpr_pkg::ADDR_CHOP] <= ctrl[sdmpr_pkg::CTRL_OTF]
                                     || !ctrl[sdmpr_pkg::CTRL_CHOP];
          rl_cnt    <= timing[31:24];
          beat      <= '0;
          data_word <= '0;
          // Spacing before next command depends on page
          wait_cnt  <= (page == sdmpr_pkg::PAGE_TRAIN) ? timing[15:8]
                                                       : timing[23:16];
          state     <= sdmpr_pkg::ST_CAPTURE;
        end
        sdmpr_pkg::ST_CAPTURE: begin
          if (rl_cnt != 8'h00) begin
            rl_cnt <= rl_cnt - 8'h01;
          end else if (dqs_s2 != dqs_prev) begin
            // Each strobe edge marks one beat; lane zero carries the bit
            data_word <= {data_word[6:0], dq_s2[0]};
            beat      <= beat + 4'h1;
            if (beat + 4'h1 == beats) begin
              state <= sdmpr_pkg::ST_RECOVER;
            end
          end
        end
        sdmpr_pkg::ST_RECOVER: begin
          if (wait_cnt == 8'h00) begin
            wait_cnt <= sdmpr_pkg::DEF_RECOV;
            state    <= sdmpr_pkg::ST_EXIT;
          end
        end
        sdmpr_pkg::ST_EXIT: begin
          if (wait_cnt == 8'h00) begin
            cmd       <= sdmpr_pkg::CMD_MRW;
            bank_addr <= sdmpr_pkg::MR3_SEL;
            addr      <= '0;
            addr[sdmpr_pkg::MR3_TEMP] <= ctrl[sdmpr_pkg::CTRL_TEMP];
            wait_cnt  <= timing[7:0];
            state     <= sdmpr_pkg::ST_EXIT_WAIT;
          end
        end
        sdmpr_pkg::ST_EXIT_WAIT: begin
          if (wait_cnt == 8'h00) begin
            done  <= 1'b1;
            state <= sdmpr_pkg::ST_IDLE;
          end
        end
        default: state <= sdmpr_pkg::ST_IDLE;
      endcase
    end
  end

  // Assertions
  property p_enter_sets_enable;
    @(posedge sys_clk) disable iff (rst)
      (state == sdmpr_pkg::ST_ENTER) |=> (cmd == sdmpr_pkg::CMD_MRW)
        && addr[sdmpr_pkg::MR3_ENABLE] && (bank_addr == sdmpr_pkg::MR3_SEL);
  endproperty
  a_enter_sets_enable: assert property (p_enter_sets_enable)
    else $error("entry write lacks enable");

  property p_exit_clears;
    @(posedge sys_clk) disable iff (rst)
      (state == sdmpr_pkg::ST_EXIT_WAIT && $past(state) == sdmpr_pkg::ST_EXIT)
        |-> !addr[sdmpr_pkg::MR3_ENABLE] && cmd == sdmpr_pkg::CMD_MRW;
  endproperty
  a_exit_clears: assert property (p_exit_clears)
    else $error("exit write keeps enable");

  property p_read_low_bits;
    @(posedge sys_clk) disable iff (rst)
      (cmd == sdmpr_pkg::CMD_RD) |-> addr[1:0] == 2'h0 && bank_addr == loc;
  endproperty
  a_read_low_bits: assert property (p_read_low_bits)
    else $error("read address low bits nonzero");

  property p_otf_chop;
    @(posedge sys_clk) disable iff (rst)
      (cmd == sdmpr_pkg::CMD_RD && ctrl[sdmpr_pkg::CTRL_OTF])
        |-> addr[sdmpr_pkg::ADDR_CHOP];
  endproperty
  a_otf_chop: assert property (p_otf_chop)
    else $error("chop bit low under on-the-fly");

  sequence s_pre;
    cmd == sdmpr_pkg::CMD_PRE;
  endsequence
  property p_pre_gap;
    @(posedge sys_clk) disable iff (rst)
      s_pre |-> (cmd != sdmpr_pkg::CMD_MRW) [*4];
  endproperty
  a_pre_gap: assert property (p_pre_gap)
    else $error("entry too soon after precharge");

  property p_entry_gap;
    @(posedge sys_clk) disable iff (rst)
      (cmd == sdmpr_pkg::CMD_MRW && addr[sdmpr_pkg::MR3_ENABLE])
        |=> (cmd != sdmpr_pkg::CMD_RD) [*2];
  endproperty
  a_entry_gap: assert property (p_entry_gap)
    else $error("read too soon after entry");

  property p_parallel_loc;
    @(posedge sys_clk) disable iff (rst)
      (cmd == sdmpr_pkg::CMD_RD && fmt == sdmpr_pkg::FMT_PARALLEL)
        |-> bank_addr == 2'h0;
  endproperty
  a_parallel_loc: assert property (p_parallel_loc)
    else $error("parallel read off location zero");

  property p_parity_gate;
    @(posedge sys_clk) disable iff (rst)
      (cmd == sdmpr_pkg::CMD_RD && page == sdmpr_pkg::PAGE_PARITY)
        |-> ctrl[sdmpr_pkg::CTRL_PARLOG];
  endproperty
  a_parity_gate: assert property (p_parity_gate)
    else $error("parity page read without enable");
endmodule

// File: verification/sdmpr_dev_model.sv
`timescale 1ns/1ps
module sdmpr_dev_model #(
  parameter logic [2:0] PAR_LAT = 3'h5, // Arbitrary value
  parameter logic [7:0] FRAME   = 8'hA6 // Arbitrary value
) (
  // System
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Command
  input  wire logic [2:0]  cmd,
  input  wire logic [17:0] addr,
  input  wire logic [1:0]  bank_addr,
  // Sensor, data and rule breaches
  input  wire logic [1:0]  sensor,
  output logic      [7:0]  dq,
  output logic             dqs,
  output logic      [7:0]  viol
);
  logic [17:0] mr3;
  logic [1:0]  temp;
  logic [7:0]  w;
  logic [4:0]  cyc;
  logic [2:0]  b;
  logic        act, bl8, ord;
  int          t_pre, t_mrw, t_end, t_rl;
  assign b = cyc[4:2] + {ord, 2'b00};
  function automatic logic [7:0] loc_w(input logic [1:0] l);
    case (mr3[1:0])
      2'h0: return l[1] ? (l[0] ? 8'h00 : 8'h0F) : (l[0] ? 8'h33 : 8'h55);
      2'h1: return (l == 2'h3) ? {5'h00, PAR_LAT} : FRAME;
      2'h2: return (l == 2'h0) ? {3'h0, temp, 3'h0} : 8'h00;
      default: return 8'hC3;
    endcase
  endfunction
  always @(posedge sys_clk) begin
    if (rst) begin
      {mr3, act, dqs, dq, viol, temp, cyc} <= '0;
      t_pre <= 999;
      t_end <= 999;
      t_rl  <= 0;
    end else begin
      t_pre <= t_pre + 1;
      t_mrw <= t_mrw + 1;
      t_end <= t_end + 1;
      if (t_rl > 0) t_rl <= t_rl - 1;
      // Released lanes must never show a stale value
      dq <= ~dq;
      if (mr3[sdmpr_pkg::MR3_TEMP]) temp <= sensor;
      if (cmd == sdmpr_pkg::CMD_PRE) t_pre <= 1;
      if (cmd == sdmpr_pkg::CMD_MRW) begin
        t_mrw <= 1;
        if (bank_addr == sdmpr_pkg::MR3_SEL) mr3 <= addr;
        if (addr[2] ? t_pre < 4 : t_end < 2) viol <= viol + 1;
      end
      if (cmd == sdmpr_pkg::CMD_RD) begin
        if (!mr3[2] || t_mrw < 24 || addr[1:0] != 0) viol <= viol + 1;
        w     <= loc_w(bank_addr);
        ord   <= addr[2];
        bl8   <= addr[12];
        t_rl  <= 16;
        cyc   <= '0;
      end
      if (t_rl == 1) act <= 1'b1;
      if (act) begin
        if (mr3[12:11] == sdmpr_pkg::FMT_PARALLEL) begin
          for (int i = 0; i < 8; i++) dq[i] <= w[7-i];
        end else begin
          dq <= {8{w[3'd7 - b]}};
        end
        if (cyc[1:0] == 2'd1) dqs <= ~dqs;
        cyc <= cyc + 1;
        if (cyc == (bl8 ? 5'd31 : 5'd15)) begin
          act   <= 1'b0;
          t_end <= 1;
        end
      end
    end
  end
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
  localparam logic [2:0] PLAT = 3'h5;
  localparam logic [7:0] FRM  = 8'hA6;
  typedef struct {logic [31:0] v; logic [31:0] m;} sdmpr_note_t;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, c, r;
  logic        avs_waitrequest, dqs;
  logic [2:0]  cmd;
  logic [17:0] addr;
  logic [1:0]  bank_addr, bank_group, sensor = 2'h0, s0;
  logic [7:0]  dq, viol, p, e8;
  int          errors = 0, cmp_count = 0, seed = 32'h0ead, ncmd = 0, n0;
  sdmpr_note_t q[$];
  sdmpr_ctrl #(.DQ_W(8)) sdmpr_ctrl_i (.sys_clk, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .cmd, .addr, .bank_addr, .bank_group, .dq_in(dq), .dqs_in(dqs));
  sdmpr_dev_model #(.PAR_LAT(PLAT), .FRAME(FRM)) sdmpr_dev_model_i (
    .sys_clk, .rst, .cmd, .addr, .bank_addr, .sensor, .dq, .dqs, .viol);
  always #10 sys_clk = ~sys_clk;
  function automatic logic [31:0] mk(input logic [1:0] pg, input logic [1:0] l,
    input logic [1:0] f, input logic o, ch, tp, ot, pr);
    return {20'h0, pr, ot, tp, ch, o, f, l, pg, 1'b0};
  endfunction
  task automatic miss(input string s);
    errors++;
    $display("MISMATCH %0t %s", $time, s);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [31:0] e, input logic [31:0] m, input logic hold);
    int n;
    n = 0;
    if (!w) q.push_back('{e, m});
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    // Waitrequest is looked at on the rising edge, before that edge moves it
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) miss("no bus answer");
    r = avs_readdata;
    if (!hold) begin
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  // Polls status, then checks status and captured word
  task automatic fin(input logic [31:0] e, m, input logic [2:0] st, sm);
    int n;
    n = 0;
    do begin
      bus(0, 4'h1, 0, 0, 0, 0);
      n++;
    end while (r[0] !== 1'b0 && n < 300);
    bus(0, 4'h1, 0, {29'h0, st}, {29'h0, sm}, 0);
    bus(0, 4'h2, 0, e, m, 0);
  endtask
  task automatic run(input logic [31:0] k, e, m, input logic [2:0] st, sm);
    c = k;
    bus(1, 4'h0, k | 32'h1, 0, 0, 0);
    fin(e, m, st, sm);
  endtask
  task automatic conclude;
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (q[0].m != 0) cmp_count++;
      if ((avs_readdata & q[0].m) !== (q[0].v & q[0].m)) miss("read data");
      void'(q.pop_front());
    end
    if (!rst && cmd !== sdmpr_pkg::CMD_NOP) ncmd++;
    if (!rst && cmd === sdmpr_pkg::CMD_RD) begin
      cmp_count++;
      if ({addr[12], addr[2:0], bank_addr} !==
          {c[10] | ~c[8], c[7], 2'b00, c[4:3]}) miss("read cmd");
    end
    if (!rst && cmd === sdmpr_pkg::CMD_MRW && addr[2] === 1'b1) begin
      cmp_count++;
      if ({addr[12:11], addr[5], addr[1:0], bank_group} !==
          {c[6:5], c[9], c[2:1], 2'b00})
        miss("entry");
    end
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    miss("timeout");
    conclude();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(0, 4'h0, 0, 0, '1, 0);
    bus(0, 4'h1, 0, 0, '1, 0);
    bus(0, 4'h3, 0, 32'h1006_0418, '1, 0);
    bus(1, 4'hF, '1, 0, 0, 0);
    bus(0, 4'hF, 0, 0, '1, 0);
    for (int i = 0; i < 16; i++) begin
      p  = i[1] ? (i[0] ? 8'h00 : 8'h0F) : (i[0] ? 8'h33 : 8'h55);
      e8 = i[2] ? {p[3:0], p[7:4]} : p;
      run(mk(0, i[1:0], 0, i[2], i[3], 0, !i[3] && $random(seed) % 2, 0),
        i[3] ? {28'h0, e8[7:4]} : e8, i[3] ? 8'h0F : 8'hFF, 2, 6);
    end
    run(mk(1, 3, 0, 0, 0, 0, 0, 1), PLAT, 8'h07, 2, 6);
    run(mk(1, 2, 0, 0, 0, 0, 0, 1), FRM & 8'hFD, 8'hFF, 2, 6);
    run(mk(3, $random(seed) % 4, 0, 0, 0, 0, 0, 0), 0, 0, 2, 6);
    run(mk(0, 0, 1, 1, 0, 0, 0, 0), 0, 8'hFF, 2, 6);
    run(mk(0, 0, 2, 0, 0, 0, 0, 0), 0, 0, 2, 6);
    s0 = {$random(seed)} % 3;
    sensor <= s0;
    run(mk(2, 0, 0, 0, 0, 1, 0, 0), {s0, 3'h0}, 8'hFF, 2, 6);
    run(mk(2, 0, 0, 0, 0, 0, 0, 0), {s0, 3'h0}, 8'hFF, 2, 6);
    sensor <= (s0 == 2'h2) ? 2'h0 : s0 + 2'h1;
    run(mk(2, 0, 0, 0, 0, 0, 0, 0), {s0, 3'h0}, 8'hFF, 2, 6);
    s0 = sensor;
    run(mk(2, 0, 0, 0, 0, 1, 0, 0), {s0, 3'h0}, 8'hFF, 2, 6);
    n0 = ncmd;
    run(mk(0, 1, 1, 0, 0, 0, 0, 0), 0, 0, 4, 4);
    run(mk(0, 0, 3, 0, 0, 0, 0, 0), 0, 0, 4, 4);
    run(mk(1, 0, 0, 0, 0, 0, 0, 0), 0, 0, 4, 4);
    cmp_count++;
    if (ncmd !== n0) miss("commands on refused request");
    // Second go while busy must be dropped
    c = mk(0, 1, 0, 0, 0, 0, 0, 0);
    bus(1, 4'h0, c | 32'h1, 0, 0, 0);
    bus(0, 4'h1, 0, 1, 1, 1);
    bus(1, 4'h0, mk(0, 2, 0, 1, 0, 0, 0, 0) | 32'h1, 0, 0, 0);
    fin(8'h33, 8'hFF, 2, 6);
    cmp_count++;
    if (viol !== 8'h00) miss("device timing broken");
    conclude();
  end
endmodule
